/* rtl/hbridge_pwm_six_channel.sv */
// Strobed register access was decided locally.
`include "modulator_consts.svh"

module hbridge_pwm_six_channel (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [31:0]          addr_i,
    input  wire modulator_pkg::word_t wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic [15:0]               rdata_o,
    input  wire logic                 sync_pin_i,
    input  wire logic                 trip_pin_i,
    output logic                      trip_irq_o,
    output logic                      pair_a_high_o,
    output logic                      pair_a_low_o,
    output logic                      pair_b_high_o,
    output logic                      pair_b_low_o,
    output logic                      pair_c_high_o,
    output logic                      pair_c_low_o
);
    import modulator_pkg::*;

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    top_state_s  st_r;
    top_state_s  st_nxt;
    logic [2:0]  pair_hi;
    logic [2:0]  pair_lo;

    pair_if pif[3] ();

    // Reset released through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            assign pif[g].tick = st_r.tick;
            assign pif[g].clr  = st_r.clr;
            assign pif[g].load = st_r.ctrl[`MOD_BIT_LOAD];
            assign pif[g].rise = st_r.sw[g][`MOD_REG_RISE];
            assign pif[g].fall = st_r.sw[g][`MOD_REG_FALL];
            assign pif[g].lowf = st_r.sw[g][`MOD_REG_LOWF];
            assign pif[g].len  = st_r.sw[g][`MOD_REG_LEN];
            assign pair_hi[g]  = pif[g].hi;
            assign pair_lo[g]  = pif[g].lo;

            modulator_pair u_pair (
                .clk_i   (clk_i),
                .rst_n_i (rst_n),
                .p       (pif[g])
            );
        end
    endgenerate

    function automatic logic [31:0] pair_addr(input int p, input int k);
        pair_addr = `MOD_ADDR_PAIR_BASE + 32'(p) * `MOD_PAIR_STRIDE
                    + 32'(k) * `MOD_REG_STRIDE;
    endfunction

    logic        sync_fall;
    logic        trip_hit;
    logic [2:0]  presc_sel;
    logic [7:0]  presc_mask;
    logic        bridge;
    logic        high_side_off;
    logic        inv;
    logic        ena;
    logic        a_active;
    logic        idle_lvl;
    logic [2:0]  low_inv;
    logic [2:0]  lo_eff;

    always_comb begin
        st_nxt = st_r;

        // Pins come from outside the clock domain
        st_nxt.sync_pin = {st_r.sync_pin[1:0], sync_pin_i};
        st_nxt.trip_pin = {st_r.trip_pin[0], trip_pin_i};
        sync_fall = st_r.sync_pin[2] & ~st_r.sync_pin[1];
        trip_hit  = st_r.ctrl[`MOD_BIT_TRIP_EN] & ~st_r.trip_pin[1];

        // Prescaler clears on the edge after the fall is seen, pair counters one edge later
        st_nxt.clr = sync_fall & st_r.ctrl[`MOD_BIT_SYNC];

        presc_sel  = st_r.ctrl[`MOD_BIT_PRESC_HI:`MOD_BIT_PRESC_LO];
        presc_mask = 8'((9'h002 << presc_sel) - 9'h001);
        if (st_nxt.clr) begin
            st_nxt.presc = 8'h00;
            st_nxt.tick  = 1'b0;
        end else begin
            st_nxt.presc = st_r.presc + 8'h01;
            st_nxt.tick  = ((st_r.presc & presc_mask) == presc_mask);
        end

        // Register writes; bit 15 of ctrl is kept at zero, pair registers take all 16 bits
        if (wr_i) begin
            if (addr_i == `MOD_ADDR_CTRL) begin
                st_nxt.ctrl = wdata_i & `MOD_CTRL_WMASK;
            end
            for (int p = 0; p < 3; p++) begin
                for (int k = 0; k < 4; k++) begin
                    if (addr_i == pair_addr(p, k)) begin
                        st_nxt.sw[p][k] = wdata_i;
                    end
                end
            end
            if (addr_i == `MOD_ADDR_IRQ_CLEAR) begin
                st_nxt.irq = 1'b0;
            end
        end

        // Trip wins over a simultaneous software write or clear
        if (trip_hit) begin
            st_nxt.ctrl[`MOD_BIT_ENABLE] = 1'b0;
            st_nxt.irq                   = 1'b1;
        end

        st_nxt.rdata = 16'h0000;
        if (rd_i) begin
            if (addr_i == `MOD_ADDR_CTRL) begin
                st_nxt.rdata = st_r.ctrl;
            end
            if (addr_i == `MOD_ADDR_STATUS) begin
                st_nxt.rdata[`MOD_STAT_IRQ]      = st_r.irq;
                st_nxt.rdata[`MOD_STAT_TRIP_LVL] = st_r.trip_pin[1];
            end
            for (int p = 0; p < 3; p++) begin
                for (int k = 0; k < 4; k++) begin
                    if (addr_i == pair_addr(p, k)) begin
                        st_nxt.rdata = st_r.sw[p][k];
                    end
                end
            end
        end

        // Output selection
        bridge   = st_r.ctrl[`MOD_BIT_BRIDGE];
        high_side_off     = bridge & st_r.ctrl[`MOD_BIT_HIGH_SIDE_OFF];
        inv      = bridge & st_r.ctrl[`MOD_BIT_INVERT];
        ena      = st_r.ctrl[`MOD_BIT_BR_ENA] & st_r.ctrl[`MOD_BIT_ENABLE];
        a_active = st_r.ctrl[`MOD_BIT_DIR] ^ inv;
        idle_lvl = inv;
        low_inv  = st_r.ctrl[`MOD_BIT_LOW_INV0 + 2:`MOD_BIT_LOW_INV0];
        lo_eff   = pair_lo ^ low_inv;

        if (!bridge) begin
            if (st_r.ctrl[`MOD_BIT_ENABLE]) begin
                st_nxt.outs = {lo_eff[2], pair_hi[2], lo_eff[1], pair_hi[1],
                               lo_eff[0], pair_hi[0]};
            end else begin
                st_nxt.outs = 6'h00;
            end
        end else begin
            // Pair c keeps modulating; invert applies to it in bridge mode
            st_nxt.outs[5:4] = {lo_eff[2], pair_hi[2]} ^ {2{inv}};
            if (high_side_off) begin
                st_nxt.outs[3:0] = 4'h5;
            end else if (!ena) begin
                st_nxt.outs[3:0] = 4'hf;
            end else if (a_active) begin
                st_nxt.outs[1:0] = {lo_eff[0], pair_hi[0]};
                st_nxt.outs[3:2] = {2{idle_lvl}};
            end else begin
                st_nxt.outs[1:0] = {2{idle_lvl}};
                st_nxt.outs[3:2] = {lo_eff[0], pair_hi[0]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= '0;
            st_r.ctrl <= `MOD_CTRL_RESET;
            st_r.outs <= 6'h05;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o       = st_r.rdata;
    assign trip_irq_o    = st_r.irq;
    assign pair_a_high_o = st_r.outs[0];
    assign pair_a_low_o  = st_r.outs[1];
    assign pair_b_high_o = st_r.outs[2];
    assign pair_b_low_o  = st_r.outs[3];
    assign pair_c_high_o = st_r.outs[4];
    assign pair_c_low_o  = st_r.outs[5];

endmodule // hbridge_pwm_six_channel

/* inc/modulator_consts.svh */
`ifndef MODULATOR_CONSTS_SVH
`define MODULATOR_CONSTS_SVH

`define MOD_ADDR_CTRL       32'hffff0f80
`define MOD_ADDR_PAIR_BASE  32'hffff0f84
`define MOD_PAIR_STRIDE     32'h00000010
`define MOD_REG_STRIDE      32'h00000004
`define MOD_ADDR_IRQ_CLEAR  32'hffff0fb8
`define MOD_ADDR_STATUS     32'hffff0fbc

`define MOD_CTRL_RESET      16'h0012
`define MOD_CTRL_WMASK      16'h7fff

`define MOD_BIT_ENABLE      0
`define MOD_BIT_BRIDGE      1
`define MOD_BIT_DIR         2
`define MOD_BIT_LOAD        3
`define MOD_BIT_HIGH_SIDE_OFF        4
`define MOD_BIT_INVERT      5
`define MOD_BIT_PRESC_LO    6
`define MOD_BIT_PRESC_HI    8
`define MOD_BIT_BR_ENA      9
`define MOD_BIT_TRIP_EN     10
`define MOD_BIT_LOW_INV0    11
`define MOD_BIT_SYNC        14

`define MOD_STAT_IRQ        0
`define MOD_STAT_TRIP_LVL   1

`define MOD_REG_RISE        0
`define MOD_REG_FALL        1
`define MOD_REG_LOWF        2
`define MOD_REG_LEN         3

`endif

/* inc/modulator_pkg.sv */
package modulator_pkg;

    typedef logic [15:0] word_t;

    typedef struct packed {
        word_t cnt;
        word_t rise_sh;
        word_t fall_sh;
        word_t lowf_sh;
        logic  hi;
        logic  lo;
    } pair_state_s;

    typedef struct packed {
        word_t                  ctrl;
        logic [2:0][3:0][15:0]  sw;
        logic [2:0]             sync_pin;
        logic [1:0]             trip_pin;
        logic [7:0]             presc;
        logic                   tick;
        logic                   clr;
        logic                   irq;
        word_t                  rdata;
        logic [5:0]             outs;
    } top_state_s;

endpackage

/* inc/pair_if.sv */
interface pair_if;
    logic        tick;
    logic        clr;
    logic        load;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] lowf;
    logic [15:0] len;
    logic        hi;
    logic        lo;

    modport ctl  (output tick, output clr, output load, output rise, output fall,
                  output lowf, output len, input hi, input lo);
    modport pair (input tick, input clr, input load, input rise, input fall,
                  input lowf, input len, output hi, output lo);
endinterface

/* rtl/modulator_pair.sv */
module modulator_pair (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    pair_if.pair      p
);
    import modulator_pkg::*;

    pair_state_s st_r;
    pair_state_s st_nxt;
    word_t       c;

    always_comb begin
        st_nxt = st_r;
        c      = st_r.cnt;
        if (p.clr) begin
            st_nxt.cnt = '0;
        end else if (p.tick) begin
            // Wrap after the period length has been reached
            c = (st_r.cnt == p.len) ? 16'h0000 : st_r.cnt + 16'h0001;
            st_nxt.cnt = c;
            if (p.load && st_r.cnt == 16'h0000 && c == 16'h0001) begin
                st_nxt.rise_sh = p.rise;
                st_nxt.fall_sh = p.fall;
                st_nxt.lowf_sh = p.lowf;
            end
            if (c == st_nxt.rise_sh) begin
                st_nxt.hi = 1'b1;
            end
            // Fall wins when both compare values coincide
            if (c == st_nxt.fall_sh) begin
                st_nxt.hi = 1'b0;
            end
            if (c == p.len) begin
                st_nxt.lo = 1'b1;
            end
            if (c == st_nxt.lowf_sh || (st_r.hi && !st_nxt.hi)) begin
                st_nxt.lo = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign p.hi = st_r.hi;
    assign p.lo = st_r.lo;

endmodule // modulator_pair

/* verification/pwm_chk.sv */
`include "modulator_consts.svh"
module pwm_chk (
    input wire logic                 clk_i,
    input wire logic                 resetn_i,
    input wire logic [31:0]          addr_i,
    input wire modulator_pkg::word_t wdata_i,
    input wire logic                 wr_i,
    input wire logic                 trip_pin_i,
    input wire logic                 trip_irq_o,
    input wire logic                 pair_a_high_o,
    input wire logic                 pair_a_low_o,
    input wire logic                 pair_b_high_o,
    input wire logic                 pair_b_low_o,
    input wire logic                 pair_c_high_o,
    input wire logic                 pair_c_low_o
);
    import modulator_pkg::*;
    // Shadow of the written word; a trip clears bit 0 behind its back
    word_t      c_r;
    logic [2:0] age_r;
    logic       clr;
    logic       cfg;
    logic [3:0] ab;
    assign clr = wr_i && addr_i == `MOD_ADDR_IRQ_CLEAR;
    assign cfg = age_r == 3'h7;
    assign ab  = {pair_a_high_o, pair_a_low_o, pair_b_high_o, pair_b_low_o};
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c_r   <= `MOD_CTRL_RESET;
            age_r <= 3'h0;
        end else if (wr_i && addr_i == `MOD_ADDR_CTRL) begin
            c_r   <= wdata_i & `MOD_CTRL_WMASK;
            age_r <= 3'h0;
        end else if (!cfg) begin
            age_r <= age_r + 3'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    high_side_off_force_a: assert property (cfg && c_r[5:4] == 2'h1 && c_r[1]
        && c_r[12:11] == 2'h0 |-> ab == 4'ha) else $error("high_side_off pattern");
    bridge_off_a: assert property (cfg && c_r[1] && !c_r[4] && !c_r[9]
        && c_r[12:11] == 2'h0 |-> ab == 4'hf) else $error("bridge off pattern");
    idle_pair_a: assert property (cfg && c_r[10:9] == 2'h1 && !c_r[4]
        && c_r[1:0] == 2'h3 && c_r[12:11] == 2'h0
        |-> (c_r[2] ^ c_r[5] ? ab[1:0] : ab[3:2]) == {2{c_r[5]}}) else $error("idle pair");
    std_off_a: assert property (cfg && c_r[1:0] == 2'h0
        |-> {pair_a_high_o, pair_b_high_o, pair_c_high_o} == 3'h0) else $error("std off");
    std_low_off_a: assert property (cfg && c_r[1:0] == 2'h0
        |-> {pair_c_low_o, pair_b_low_o, pair_a_low_o} == 3'h0) else $error("std low off");
    irq_set_a: assert property ((cfg && c_r[10] && !trip_pin_i)[*4]
        |=> trip_irq_o) else $error("trip irq missing");
    irq_cause_a: assert property ($rose(trip_irq_o) |-> $past(c_r[10])
        && !($past(trip_pin_i, 3) && $past(trip_pin_i, 4) && $past(trip_pin_i, 5)))
        else $error("irq without trip");
    irq_fall_a: assert property ($fell(trip_irq_o)
        |-> $past(clr) || $past(clr, 2)) else $error("irq dropped");
endmodule // pwm_chk

bind hbridge_pwm_six_channel pwm_chk u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .trip_pin_i(trip_pin_i), .trip_irq_o(trip_irq_o),
    .pair_a_high_o(pair_a_high_o), .pair_a_low_o(pair_a_low_o),
    .pair_b_high_o(pair_b_high_o), .pair_b_low_o(pair_b_low_o),
    .pair_c_high_o(pair_c_high_o), .pair_c_low_o(pair_c_low_o));

/* verification/stage_model.sv */
module stage_model (
    input  wire logic fault_i,
    input  wire logic sync_i,
    output logic      trip_n_o,
    output logic      sync_n_o
);
    // Fault line driven high when idle; pulled low only on a commanded fault
    assign trip_n_o = !fault_i;
    assign sync_n_o = !sync_i;
endmodule // stage_model

/* verification/tb_hbridge_pwm_six_channel.sv */
`include "modulator_consts.svh"
module tb_hbridge_pwm_six_channel;
    timeunit 1ns;
    timeprecision 1ns;
    import modulator_pkg::*;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic [31:0] addr_i   = 32'h0;
    word_t       wdata_i  = 16'h0;
    logic        wr_i     = 1'b0;
    logic        rd_i     = 1'b0;
    logic        fault    = 1'b0;
    logic        sync_req = 1'b0;
    logic        trip_n;
    logic        sync_n;
    logic        irq;
    logic [15:0] rdata;
    logic [5:0]  outs;
    int          err_total = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    hbridge_pwm_six_channel DUT (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .sync_pin_i(sync_n),
        .trip_pin_i(trip_n), .trip_irq_o(irq), .pair_a_high_o(outs[5]),
        .pair_a_low_o(outs[4]), .pair_b_high_o(outs[3]), .pair_b_low_o(outs[2]),
        .pair_c_high_o(outs[1]), .pair_c_low_o(outs[0]));
    stage_model u_stage (.fault_i(fault), .sync_i(sync_req), .trip_n_o(trip_n),
        .sync_n_o(sync_n));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [31:0] a, input word_t d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        tick(1);
        wr_i    <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [31:0] a, input word_t e);
        addr_i <= a;
        rd_i   <= 1'b1;
        tick(1);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        chk(rdata, e);
        tick(1);
    endtask
    // Bounded so a stuck output shows up as a wrong width, not a hang
    task automatic seek(input int i, input logic v, output int n);
        n = 0;
        while (outs[i] !== v && n < 4000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_pwm();
        int    hw;
        int    lw;
        int    i;
        word_t v[4] = '{16'h2, 16'h5, 16'h1, 16'h9};
        for (int p = 0; p < 12; p++) begin
            wr(`MOD_ADDR_PAIR_BASE + 32'(p / 4) * `MOD_PAIR_STRIDE
               + 32'(p % 4) * `MOD_REG_STRIDE, v[p % 4]);
        end
        rd(`MOD_ADDR_PAIR_BASE + 32'h0000002c, 16'h0009);
        wr(`MOD_ADDR_CTRL, 16'h0001);
        tick(40);
        chk(16'(outs[5]), 16'h0);
        for (int c = 0; c < 8; c++) begin
            i = 5 - 2 * (c % 3);
            wr(`MOD_ADDR_CTRL, 16'h0009 | 16'(c) << 6);
            // First tick after a prescale change is off grid; let it pass
            tick(300);
            seek(i, 1'b0, hw);
            seek(i, 1'b1, hw);
            seek(i, 1'b0, hw);
            seek(i, 1'b1, lw);
            chk(16'(hw), 16'(3 << (c + 1)));
            chk(16'(hw + lw), 16'(10 << (c + 1)));
        end
        seek(4, 1'b0, hw);
        seek(4, 1'b1, hw);
        seek(4, 1'b0, hw);
        chk(16'(hw), 16'h0200);
    endtask
    task automatic t_modes();
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(`MOD_ADDR_CTRL, 16'h0001 | 16'h0800 << i);
            // At the high-side rise the low sides sit low, so only inversion shows
            seek(5, 1'b0, n);
            seek(5, 1'b1, n);
            chk(16'({outs[0], outs[2], outs[4]}), 16'(1 << i));
        end
        wr(`MOD_ADDR_CTRL, 16'h3800);
        tick(8);
        chk(16'(outs), 16'h0000);
        wr(`MOD_ADDR_CTRL, 16'h0003);
        tick(8);
        chk(16'(outs[5:2]), 16'h000f);
        wr(`MOD_ADDR_CTRL, 16'h0032);
        tick(8);
        chk(16'(outs[5:2]), 16'h000a);
        for (int m = 0; m < 4; m++) begin
            wr(`MOD_ADDR_CTRL, 16'h0203 | 16'(m % 2) << 2 | 16'(m / 2) << 5);
            tick(8);
            chk(16'((m % 2 != m / 2) ? outs[3:2] : outs[5:4]), 16'(m / 2 * 3));
        end
    endtask
    task automatic t_sync(input word_t c, input logic [15:0] e);
        int   n;
        logic p;
        wr(`MOD_ADDR_CTRL, c);
        n = 0;
        p = outs[5];
        for (int k = 0; k < 96; k++) begin
            sync_req <= (k % 8 == 0);
            tick(1);
            n += int'(outs[5] !== p);
            p = outs[5];
        end
        chk(16'(n > 3), e);
    endtask
    task automatic t_trip(input word_t c, input logic [15:0] e);
        wr(`MOD_ADDR_CTRL, c);
        fault <= 1'b1;
        tick(10);
        chk(16'(irq), e);
        rd(`MOD_ADDR_STATUS, e);
        rd(`MOD_ADDR_CTRL, c & ~e);
        wr(`MOD_ADDR_IRQ_CLEAR, 16'h0);
        tick(2);
        chk(16'(irq), e);
        fault <= 1'b0;
        tick(6);
        wr(`MOD_ADDR_IRQ_CLEAR, 16'h5);
        tick(2);
        chk(16'(irq), 16'h0);
    endtask
    initial begin
        tick(5);
        resetn_i <= 1'b1;
        tick(3);
        rd(`MOD_ADDR_CTRL, `MOD_CTRL_RESET);
        chk(16'(outs), 16'h0028);
        rd(32'hffff0fb4, 16'h0000);
        t_pwm();
        t_modes();
        t_sync(16'h4009, 16'h0);
        t_sync(16'h0009, 16'h1);
        t_trip(16'h0401, 16'h1);
        t_trip(16'h0001, 16'h0);
        end_sim();
    end
endmodule // tb_hbridge_pwm_six_channel
